// ==== verilog/tawd_watchdog.sv ====
`timescale 1ns/1ps
module tawd_watchdog #(
   parameter logic [7:0] ID_CODE       = 8'h5A, // arbitrary value
   parameter int         CONV_FIRST_US = tawd_pkg::CONV_FIRST_US,
   parameter int         RATE0_US      = tawd_pkg::RATE0_US,
   parameter int         RATE1_US      = tawd_pkg::RATE1_US,
   parameter int         RATE2_US      = tawd_pkg::RATE2_US,
   parameter int         RATE3_US      = tawd_pkg::RATE3_US
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst_b,
   input  wire logic [tawd_pkg::WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [31:0]                   wb_dat_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic                          wb_we_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic [tawd_pkg::TEMP_W-1:0]   adc_result,
   input  wire logic                          addr_pin_two,
   input  wire logic                          addr_pin_one,
   input  wire logic                          addr_pin_zero,
   input  wire logic                          scl_i,
   input  wire logic                          sda_i,
   output logic                               sda_o,
   output logic                               sda_oe_n,
   output logic                               thermal_alarm_out_o,
   output logic                               thermal_alarm_out_oe_n
);

   ////////////////////////////////////////////////////////////////////////
   // register bus decode
   tawd_pkg::tawd_conf_t          conf;
   tawd_pkg::tawd_stat_t          stat;
   logic [8:0]                    tos_lim;
   logic [8:0]                    thyst_lim;
   logic [tawd_pkg::TEMP_W-1:0]   temp;
   logic                          temp_valid;
   logic                          alarm;
   logic                          hunt_low;
   logic                          link_read;

   wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [7:0]  ptr      = wb_adr_i[tawd_pkg::WB_ADR_W-1:2];
   wire        wr       = wb_req & wb_we_i;
   wire        rd       = wb_req & ~wb_we_i;
   wire        sel_temp = (ptr == tawd_pkg::PTR_TEMP);
   wire        sel_conf = (ptr == tawd_pkg::PTR_CONF);
   wire        sel_thys = (ptr == tawd_pkg::PTR_THYST);
   wire        sel_tos  = (ptr == tawd_pkg::PTR_TOS);
   wire        sel_id   = (ptr == tawd_pkg::PTR_ID);
   wire        sel_stat = (ptr == tawd_pkg::PTR_STAT);
   wire        mapped   = sel_temp | sel_conf | sel_thys | sel_tos |
                          sel_id | sel_stat;
   wire        reg_read = (rd & mapped) | link_read;
   wire [15:0] temp_word  = {temp, 3'h0};
   wire [15:0] tos_word   = {tos_lim, 7'h00};
   wire [15:0] thyst_word = {thyst_lim, 7'h00};

   assign stat.hunt_low   = hunt_low;
   assign stat.alarm      = alarm;
   assign stat.temp_valid = temp_valid;
   assign stat.converting = ~conf.shutdown;

   // unmapped indices answer with zero data and ignore writes
   wire [31:0] rd_word =
      sel_temp ? {16'h0000, temp_word} :
      sel_conf ? {24'h000000, conf} :
      sel_thys ? {16'h0000, thyst_word} :
      sel_tos  ? {16'h0000, tos_word} :
      sel_id   ? {24'h000000, ID_CODE} :
      sel_stat ? {28'h0000000, stat} : 32'h00000000;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         if (rd) begin
            wb_dat_o <= rd_word;
         end
      end
   end

   // bus writes land while shutdown too; only conversions stop
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         conf      <= tawd_pkg::CONF_RST;
         tos_lim   <= tawd_pkg::TOS_RST[15:7];
         thyst_lim <= tawd_pkg::THYST_RST[15:7];
      end else if (wr) begin
         if (sel_conf && wb_sel_i[0]) begin
            conf <= wb_dat_i[7:0];
         end
         if (sel_tos && wb_sel_i[0]) begin
            tos_lim[0] <= wb_dat_i[tawd_pkg::LIM_LSB];
         end
         if (sel_tos && wb_sel_i[1]) begin
            tos_lim[8:1] <= wb_dat_i[15:8];
         end
         if (sel_thys && wb_sel_i[0]) begin
            thyst_lim[0] <= wb_dat_i[tawd_pkg::LIM_LSB];
         end
         if (sel_thys && wb_sel_i[1]) begin
            thyst_lim[8:1] <= wb_dat_i[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion timing on a microsecond enable
   logic [7:0]                      us_cnt;
   logic                            us_tick;
   logic [tawd_pkg::CONV_CNT_W-1:0] conv_cnt;
   logic [tawd_pkg::CONV_CNT_W-1:0] conv_target;
   logic                            first_conv;
   logic                            conv_done;
   logic                            eval_stb;

   always_comb begin
      case (conf.rate_sel)
         2'h0:    conv_target = tawd_pkg::CONV_CNT_W'(RATE0_US - 1);
         2'h1:    conv_target = tawd_pkg::CONV_CNT_W'(RATE1_US - 1);
         2'h2:    conv_target = tawd_pkg::CONV_CNT_W'(RATE2_US - 1);
         2'h3:    conv_target = tawd_pkg::CONV_CNT_W'(RATE3_US - 1);
         default: conv_target = tawd_pkg::CONV_CNT_W'(RATE0_US - 1);
      endcase
      if (first_conv) begin
         conv_target = tawd_pkg::CONV_CNT_W'(CONV_FIRST_US - 1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         us_cnt  <= 8'h00;
         us_tick <= 1'b0;
      end else begin
         us_tick <= (us_cnt == 8'(tawd_pkg::CYC_PER_US - 1));
         if (us_cnt == 8'(tawd_pkg::CYC_PER_US - 1)) begin
            us_cnt <= 8'h00;
         end else begin
            us_cnt <= us_cnt + 8'h01;
         end
      end
   end

   // leaving shutdown starts a fresh conversion from zero
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         conv_cnt   <= '0;
         first_conv <= 1'b1;
         conv_done  <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         if (conf.shutdown) begin
            conv_cnt <= '0;
         end else if (us_tick) begin
            if (conv_cnt >= conv_target) begin
               conv_cnt   <= '0;
               first_conv <= 1'b0;
               conv_done  <= 1'b1;
            end else begin
               conv_cnt <= conv_cnt + 1'b1;
            end
         end
      end
   end

   // comparison runs one cycle after conv_done, in the first cycle temp holds the result
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         temp       <= '0;
         temp_valid <= 1'b0;
         eval_stb   <= 1'b0;
      end else begin
         eval_stb <= conv_done;
         if (conv_done) begin
            temp       <= adc_result;
            temp_valid <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog comparison and alarm state
   logic       sdn_q;
   logic [2:0] set_q;
   logic       fire;

   wire [8:0] temp9     = temp[tawd_pkg::TEMP_W-1:tawd_pkg::TCMP_LSB];
   wire       over      = $signed(temp9) > $signed(tos_lim);
   wire       under     = $signed(temp9) < $signed(thyst_lim);
   wire       int_mode  = conf.alarm_mode_sel;
   wire       cmp_trip  = alarm ? under : over;
   wire       int_trip  = hunt_low ? under : over;
   wire       trip      = int_mode ? int_trip : cmp_trip;
   wire [2:0] set_now   = {conf.alarm_mode_sel, conf.fault_queue_sel};
   wire       set_chg   = (set_now != set_q);
   wire       sdn_entry = conf.shutdown & ~sdn_q;

   tawd_fault_queue u_fault_queue (
      .core_clk        (core_clk),
      .rst_b           (rst_b),
      .eval_stb        (eval_stb),
      .trip            (trip),
      .restart         (set_chg),
      .fault_queue_sel (conf.fault_queue_sel),
      .fire            (fire)
   );

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sdn_q <= 1'b0;
         set_q <= 3'h0;
      end else begin
         sdn_q <= conf.shutdown;
         set_q <= set_now;
      end
   end

   // a new fault beats a same-cycle read or shutdown clear
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         alarm    <= 1'b0;
         hunt_low <= 1'b0;
      end else if (set_chg) begin
         alarm    <= 1'b0;
         hunt_low <= 1'b0;
      end else if (fire) begin
         if (int_mode) begin
            alarm    <= 1'b1;
            hunt_low <= ~hunt_low;
         end else begin
            alarm <= ~alarm;
         end
      end else if (int_mode && (reg_read || sdn_entry)) begin
         alarm <= 1'b0;
      end
   end

   // pin level is only valid while tos stays above thyst
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         thermal_alarm_out_oe_n <= 1'b1;
      end else begin
         thermal_alarm_out_oe_n <= ~(alarm ^ conf.alarm_polarity);
      end
   end

   assign thermal_alarm_out_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // serial link: address recognition and acknowledge
   logic [2:0]              pin_meta;
   logic [2:0]              pin_sync;
   logic [1:0]              scl_ff;
   logic [1:0]              sda_ff;
   logic                    scl_d;
   logic                    sda_d;
   logic [7:0]              shreg;
   logic [2:0]              bit_cnt;
   logic                    rw_bit;
   tawd_pkg::tawd_link_st_t lk_st;

   wire [6:0] slave_addr = {tawd_pkg::ADDR_FIXED, pin_sync};
   wire       scl_s      = scl_ff[1];
   wire       sda_s      = sda_ff[1];
   wire       scl_rise   = scl_s & ~scl_d;
   wire       scl_fall   = ~scl_s & scl_d;
   wire       start_c    = scl_s & scl_d & sda_d & ~sda_s;
   wire       stop_c     = scl_s & scl_d & ~sda_d & sda_s;
   wire [7:0] next_shreg = {shreg[6:0], sda_s};

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
         scl_ff   <= 2'h3;
         sda_ff   <= 2'h3;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end else begin
         pin_meta <= {addr_pin_two, addr_pin_one, addr_pin_zero};
         pin_sync <= pin_meta;
         scl_ff   <= {scl_ff[0], scl_i};
         sda_ff   <= {sda_ff[0], sda_i};
         scl_d    <= scl_s;
         sda_d    <= sda_s;
      end
   end

   // the link answers in shutdown as well, it never waits on conversion
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         lk_st     <= tawd_pkg::LK_IDLE;
         shreg     <= 8'h00;
         bit_cnt   <= 3'h0;
         rw_bit    <= 1'b0;
         link_read <= 1'b0;
      end else begin
         link_read <= 1'b0;
         if (start_c) begin
            lk_st   <= tawd_pkg::LK_ADDR;
            bit_cnt <= 3'h0;
         end else if (stop_c) begin
            lk_st <= tawd_pkg::LK_IDLE;
         end else begin
            case (lk_st)
               tawd_pkg::LK_ADDR: begin
                  if (scl_rise) begin
                     shreg   <= next_shreg;
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7) begin
                        rw_bit <= next_shreg[0];
                        lk_st  <= (next_shreg[7:1] == slave_addr) ?
                                  tawd_pkg::LK_ACK_WAIT :
                                  tawd_pkg::LK_IDLE;
                     end
                  end
               end
               tawd_pkg::LK_ACK_WAIT: begin
                  if (scl_fall) begin
                     lk_st     <= tawd_pkg::LK_ACK_DRIVE;
                     link_read <= rw_bit;
                  end
               end
               tawd_pkg::LK_ACK_DRIVE: begin
                  if (scl_fall) begin
                     lk_st <= tawd_pkg::LK_IDLE;
                  end
               end
               default: lk_st <= tawd_pkg::LK_IDLE;
            endcase
         end
      end
   end

   // only the address phase is served here, data bytes are not answered at all
   assign sda_oe_n = (lk_st != tawd_pkg::LK_ACK_DRIVE);
   assign sda_o    = 1'b0;

endmodule

// ==== verilog/tawd_pkg.sv ====
package tawd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and conversion timing
   localparam int CLK_FREQ_HZ    = 200_000_000;
   localparam int US_PER_S       = 1_000_000;
   localparam int US_PER_MS      = 1000;
   localparam int CYC_PER_US     = CLK_FREQ_HZ / US_PER_S;
   localparam int CONV_FIRST_MS  = 33;
   localparam int CONV_FIRST_US  = CONV_FIRST_MS * US_PER_MS;
   localparam int RATE0_MS       = 100;
   localparam int RATE1_MS       = 8000;
   localparam int RATE2_MS       = 1000;
   localparam int RATE3_PER_S    = 30;
   localparam int RATE0_US       = RATE0_MS * US_PER_MS;
   localparam int RATE1_US       = RATE1_MS * US_PER_MS;
   localparam int RATE2_US       = RATE2_MS * US_PER_MS;
   localparam int RATE3_US       = US_PER_S / RATE3_PER_S;
   localparam int CONV_CNT_W     = 24;

   ////////////////////////////////////////////////////////////////////////
   // register indices, byte address is four times the index
   localparam int          WB_ADR_W  = 10;
   localparam logic [7:0]  PTR_TEMP  = 8'h00;
   localparam logic [7:0]  PTR_CONF  = 8'h01;
   localparam logic [7:0]  PTR_THYST = 8'h02;
   localparam logic [7:0]  PTR_TOS   = 8'h03;
   localparam logic [7:0]  PTR_ID    = 8'h05;
   localparam logic [7:0]  PTR_STAT  = 8'h08;

   ////////////////////////////////////////////////////////////////////////
   // reset values and field positions
   localparam logic [7:0]  CONF_RST  = 8'h00;
   localparam logic [15:0] TOS_RST   = 16'h5000;
   localparam logic [15:0] THYST_RST = 16'h4B00;
   localparam int          LIM_LSB   = 7;
   localparam int          TEMP_W    = 13;
   localparam int          TEMP_LSB  = 3;
   localparam int          TCMP_LSB  = 4;
   localparam logic [3:0]  ADDR_FIXED = 4'h9;

   ////////////////////////////////////////////////////////////////////////
   // fault queue counts
   localparam logic [2:0]  FQ_CNT0 = 3'h1;
   localparam logic [2:0]  FQ_CNT1 = 3'h2;
   localparam logic [2:0]  FQ_CNT2 = 3'h4;
   localparam logic [2:0]  FQ_CNT3 = 3'h6;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic       reserved;
      logic [1:0] rate_sel;
      logic [1:0] fault_queue_sel;
      logic       alarm_polarity;
      logic       alarm_mode_sel;
      logic       shutdown;
   } tawd_conf_t;

   typedef struct packed {
      logic       hunt_low;
      logic       alarm;
      logic       temp_valid;
      logic       converting;
   } tawd_stat_t;

   typedef enum logic [1:0] {
      LK_IDLE,
      LK_ADDR,
      LK_ACK_WAIT,
      LK_ACK_DRIVE
   } tawd_link_st_t;

endpackage

// ==== verilog/tawd_fault_queue.sv ====
`timescale 1ns/1ps
module tawd_fault_queue (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       eval_stb,
   input  wire logic       trip,
   input  wire logic       restart,
   input  wire logic [1:0] fault_queue_sel,
   output logic            fire
);

   logic [2:0] cnt;
   logic [2:0] need;
   logic [2:0] cnt_inc;

   always_comb begin
      case (fault_queue_sel)
         2'h0:    need = tawd_pkg::FQ_CNT0;
         2'h1:    need = tawd_pkg::FQ_CNT1;
         2'h2:    need = tawd_pkg::FQ_CNT2;
         2'h3:    need = tawd_pkg::FQ_CNT3;
         default: need = tawd_pkg::FQ_CNT0;
      endcase
   end

   assign cnt_inc = cnt + 3'h1;

   // a count restarts on any miss, so only unbroken runs can fire
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cnt  <= 3'h0;
         fire <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (restart) begin
            cnt <= 3'h0;
         end else if (eval_stb) begin
            if (!trip) begin
               cnt <= 3'h0;
            end else if (cnt_inc >= need) begin
               cnt  <= 3'h0;
               fire <= 1'b1;
            end else begin
               cnt <= cnt_inc;
            end
         end
      end
   end

endmodule

// ==== sim/tawd_watchdog_asserts.sv ====
`timescale 1ns/1ps
module tawd_watchdog_asserts #(
   parameter int CONV_FIRST_US = tawd_pkg::CONV_FIRST_US
) (
   input wire logic                          core_clk,
   input wire logic                          rst_b,
   input wire logic [tawd_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [31:0]                   wb_dat_i,
   input wire logic [3:0]                    wb_sel_i,
   input wire logic                          wb_we_i,
   input wire logic                          wb_cyc_i,
   input wire logic                          wb_stb_i,
   input wire logic [31:0]                   wb_dat_o,
   input wire logic                          wb_ack_o,
   input wire logic                          sda_o,
   input wire logic                          thermal_alarm_out_o,
   input wire logic                          thermal_alarm_out_oe_n
);
   localparam int FIRST_CYC = CONV_FIRST_US * tawd_pkg::CYC_PER_US;
   logic [7:0]  conf;
   logic [3:0]  quiet;
   logic [31:0] age;
   wire  [7:0]  idx      = wb_adr_i[9:2];
   wire         wr_conf  = wb_ack_o && wb_we_i && wb_sel_i[0] && idx == 8'h01;
   wire         rd_map   = wb_ack_o && !wb_we_i && idx inside
                           {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h08};
   // inactive alarm drives the pin low only when active high is chosen
   wire         idle_oe_n = !conf[2];

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         conf  <= 8'h00;
         quiet <= 4'h0;
         age   <= 32'h0;
      end else begin
         if (wr_conf) begin
            conf <= wb_dat_i[7:0];
         end
         quiet <= wr_conf ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
         age   <= age + {31'h0, age != 32'hFFFF_FFFF};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_read_taken;
      rd_map && conf[1] && quiet == 4'hF;
   endsequence
   sequence s_pin_idle;
      ##[1:4] thermal_alarm_out_oe_n == idle_oe_n;
   endsequence

   chk_ack_next: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   chk_ack_pulse: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_rst_state: assert property (
      @(posedge core_clk) disable iff (1'b0)
      !rst_b |=> thermal_alarm_out_oe_n && !wb_ack_o && wb_dat_o == 32'h0)
      else $error("reset state wrong");
   chk_od_low: assert property (
      thermal_alarm_out_o == 1'b0 && sda_o == 1'b0) else $error("od level");
   chk_read_clear: assert property (
      s_read_taken |-> s_pin_idle) else $error("read kept alarm");
   chk_shdn_clear: assert property (
      wr_conf && wb_dat_i[1] && wb_dat_i[0] && !conf[0] |-> s_pin_idle)
      else $error("shutdown kept alarm");
   chk_cmp_hold: assert property (
      conf[0] && !conf[1] && quiet == 4'hF |=> $stable(thermal_alarm_out_oe_n))
      else $error("pin moved in shutdown");
   chk_early_temp: assert property (
      rd_map && idx == 8'h00 && age < FIRST_CYC |-> wb_dat_o == 32'h0)
      else $error("temperature before first conversion");
endmodule

bind tawd_watchdog tawd_watchdog_asserts
   #(.CONV_FIRST_US(CONV_FIRST_US)) i_chk (
   .core_clk(core_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .sda_o(sda_o),
   .thermal_alarm_out_o(thermal_alarm_out_o),
   .thermal_alarm_out_oe_n(thermal_alarm_out_oe_n));

// ==== sim/tawd_link_host.sv ====
`timescale 1ns/1ps
module tawd_link_host (
   output logic      scl,
   output logic      sda_drv,
   input  wire logic sda_line
);
   // both lines released, clock stands still between frames
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // one 80 ns period per bit, data moves only while the clock is low
   task automatic send_bit(input logic b);
      sda_drv = b;
      #20;
      scl = 1'b1;
      #40;
      scl = 1'b0;
      #20;
   endtask

   // start, address byte, ack slot, stop; 0Ch is never issued
   task automatic addr_frame(input logic [7:0] addr, output logic acked);
      #1.3;
      sda_drv = 1'b0;
      #40;
      scl = 1'b0;
      #20;
      for (int i = 7; i >= 0; i--) begin
         send_bit(addr[i]);
      end
      sda_drv = 1'b1;
      #20;
      scl = 1'b1;
      #20;
      acked = ~sda_line;
      #20;
      scl = 1'b0;
      #20;
      sda_drv = 1'b0;
      #20;
      scl = 1'b1;
      #20;
      sda_drv = 1'b1;
      #40;
   endtask
endmodule

// ==== sim/tawd_watchdog_tb.sv ====
`timescale 1ns/1ps
module tawd_watchdog_tb;
   localparam int          P_CYC  = 5 * tawd_pkg::CYC_PER_US;
   localparam int          F_CYC  = 20 * tawd_pkg::CYC_PER_US;
   localparam logic [12:0] T_HOT  = 13'h0B40;
   localparam logic [12:0] T_MID  = 13'h09A0;
   localparam logic [12:0] T_COLD = 13'h08C0;
   logic        core_clk, rst_b, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [9:0]  wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, d;
   logic [3:0]  wb_sel_i;
   logic [12:0] adc_result;
   logic [2:0]  pins;
   logic        scl, sda_drv, sda_o, sda_oe_n, alm_o, alm_oe_n, ack;
   int          mismatches, cmp_count, cycles;
   // pull-ups on both open-drain lines
   wire         sda_line  = sda_drv & (sda_oe_n | sda_o);
   wire         alarm_pin = alm_oe_n ? 1'b1 : alm_o;

   tawd_watchdog #(.CONV_FIRST_US(20), .RATE0_US(5), .RATE1_US(40),
      .RATE2_US(15), .RATE3_US(8)) i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .adc_result(adc_result),
      .addr_pin_two(pins[2]), .addr_pin_one(pins[1]),
      .addr_pin_zero(pins[0]), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .thermal_alarm_out_o(alm_o),
      .thermal_alarm_out_oe_n(alm_oe_n));
   tawd_link_host i_host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

   always #2.5 core_clk = ~core_clk;
   // run needs about 53000 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         mismatches++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] idx,
                     input logic [31:0] w, input logic [3:0] sel);
      int k;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= w;
      wb_sel_i <= sel;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      check("ack", 32'h1, {31'h0, wb_ack_o});
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] w);
      wb(1'b1, idx, w, 4'hF);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 32'h0, 4'hF);
      check("register", exp, d);
   endtask

   task automatic temp_to(input logic [12:0] v);
      @(posedge core_clk);
      adc_result <= v;
   endtask

   // waits at most hi cycles; reaching the level earlier than lo is wrong
   task automatic pin_in(input logic lvl, input int lo, input int hi);
      int k;
      k = 0;
      while (alarm_pin !== lvl && k < hi) begin
         @(posedge core_clk);
         k++;
      end
      check("alarm pin", {31'h0, lvl}, {31'h0, alarm_pin});
      check("alarm delay in window", 32'h1, {31'h0, k >= lo});
   endtask

   task automatic stay(input logic lvl, input int cyc);
      repeat (cyc) @(posedge core_clk);
      check("alarm held", {31'h0, lvl}, {31'h0, alarm_pin});
   endtask

   task automatic do_reset();
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      rdchk(8'h01, 32'h0);
      rdchk(8'h03, 32'h0000_5000);
      rdchk(8'h02, 32'h0000_4B00);
      rdchk(8'h00, 32'h0);
      rdchk(8'h04, 32'h0);
      rdchk(8'h05, 32'h0000_005A);
      check("alarm pin", 32'h1, {31'h0, alarm_pin});
   endtask

   task automatic t_first();
      repeat (F_CYC - 60) @(posedge core_clk);
      rdchk(8'h00, 32'h0);
      repeat (80) @(posedge core_clk);
      rdchk(8'h00, {16'h0, T_MID, 3'h0});
   endtask

   task automatic t_queue();
      int need [4] = '{1, 2, 4, 6};
      for (int q = 0; q < 4; q++) begin
         wr(8'h01, {27'h0, q[1:0], 3'h0});
         temp_to(T_HOT);
         pin_in(1'b0, (need[q]-1)*P_CYC, need[q] * P_CYC + 8);
         if (q == 0) begin
            temp_to(T_MID);
            stay(1'b0, 3 * P_CYC);
            rdchk(8'h00, {16'h0, T_MID, 3'h0});
            stay(1'b0, 20);
         end
         temp_to(T_COLD);
         pin_in(1'b1, (need[q]-1)*P_CYC, need[q] * P_CYC + 8);
      end
   endtask

   task automatic t_polarity();
      wr(8'h01, 32'h0000_0004);
      pin_in(1'b0, 0, 10);
      temp_to(T_HOT);
      pin_in(1'b1, 0, P_CYC + 8);
      temp_to(T_COLD);
      pin_in(1'b0, 0, P_CYC + 8);
   endtask

   task automatic t_intr();
      wr(8'h01, 32'h0000_0002);
      stay(1'b1, 2 * P_CYC);
      temp_to(T_HOT);
      pin_in(1'b0, 0, P_CYC + 8);
      stay(1'b0, 2 * P_CYC);
      rdchk(8'h01, 32'h0000_0002);
      pin_in(1'b1, 0, 8);
      stay(1'b1, 2 * P_CYC);
      temp_to(T_COLD);
      pin_in(1'b0, 0, P_CYC + 8);
      rdchk(8'h00, {16'h0, T_COLD, 3'h0});
      pin_in(1'b1, 0, 8);
      temp_to(T_HOT);
      pin_in(1'b0, 0, P_CYC + 8);
      wr(8'h01, 32'h0000_0003);
      pin_in(1'b1, 0, 8);
      wr(8'h01, 32'h0);
   endtask

   task automatic t_shutdown();
      pin_in(1'b0, 0, P_CYC + 8);
      wr(8'h01, 32'h0000_0001);
      temp_to(T_COLD);
      stay(1'b0, 3 * P_CYC);
      rdchk(8'h00, {16'h0, T_HOT, 3'h0});
      rdchk(8'h08, 32'h0000_0006);
      // upper byte only; the limit stays above hysteresis
      wb(1'b1, 8'h03, 32'h0000_53FF, 4'h2);
      rdchk(8'h03, 32'h0000_5300);
      wr(8'h01, 32'h0);
      pin_in(1'b1, 0, F_CYC + P_CYC);
      rdchk(8'h00, {16'h0, T_COLD, 3'h0});
   endtask

   task automatic t_link();
      for (int p = 0; p < 8; p++) begin
         @(posedge core_clk);
         pins <= p[2:0];
         repeat (8) @(posedge core_clk);
         i_host.addr_frame({4'h9, p[2:0], 1'b0}, ack);
         check("addr ack", 32'h1, {31'h0, ack});
         i_host.addr_frame({4'h9, ~p[2:0], 1'b0}, ack);
         check("pin mismatch ack", 32'h0, {31'h0, ack});
         i_host.addr_frame({4'h8, p[2:0], 1'b0}, ack);
         check("fixed bits ack", 32'h0, {31'h0, ack});
      end
   endtask

   task automatic conclude();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk   = 1'b0;
      rst_b      = 1'b0;
      wb_cyc_i   = 1'b0;
      wb_stb_i   = 1'b0;
      wb_we_i    = 1'b0;
      wb_adr_i   = 10'h000;
      wb_dat_i   = 32'h0;
      wb_sel_i   = 4'h0;
      adc_result = T_MID;
      pins       = 3'h0;
      mismatches = 0;
      cmp_count  = 0;
      cycles     = 0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      t_defaults();
      t_first();
      t_queue();
      t_polarity();
      t_intr();
      t_shutdown();
      wr(8'h01, 32'h0000_001E);
      do_reset();
      t_defaults();
      t_link();
      conclude();
   end
endmodule
